/* File: cum_defs.vh */
// Constants for the cache usage monitor register bank
// Notes on behaviour
// (R01) Four separate usage views, one per security state, with no shared storage.
// (R02) Each view is indexed by its own state's monitor selector only.
// (R03) Feature pages in all four maps; root and realm views only from their pages. Code has root and realm pages only with the realm extension.
// (R04) With resource select, access goes to resource index plus monitor index.
// (R05) Without resource select, access goes by monitor index alone.
// (R06) Usage register exists only when all monitoring features present; else reads zero. Code needs only partitioning, monitoring and usage monitors.
// (R07) Usage register is 32 bits wide.
// (R08) Bit 31 is the not-ready flag; one means count invalid.
// (R09) Bits 30 to 0 hold matching cache bytes in use.
// (R10) Usage register writable when read-only flag is 0, read-only when 1.
// (R11) Usage register sits at offset 0x0840 in each state's page.
// (R12) Snapshot register is 32-bit read-write copy for the selected monitor.
// (R13) With resource select, snapshot is per resource and monitor index.
// (R14) Snapshot exists only with monitoring, usage monitors and capture; else zero. Code also needs partitioning.
// (R15) Snapshot bit 31 records the not-ready flag at capture time.
// (R16) Snapshot bits 30 to 0 hold the captured byte count.
// (R17) Software sets monitor index in selector bits 15 to 0 first.
// (R18) Software sets resource index in selector bits 27 to 24 first.
// (R19) Snapshot holds until the next capture or a software write.
`ifndef CUM_DEFS_VH
`define CUM_DEFS_VH
`define CUM_OFF_SEL       12'h800
`define CUM_OFF_COUNT     12'h840
`define CUM_OFF_SNAP      12'h848
`define CUM_SEL_MON_LSB   0
`define CUM_SEL_MON_MSB   15
`define CUM_SEL_RIS_LSB   24
`define CUM_SEL_RIS_MSB   27
`define CUM_NOT_READY_FLAG_BIT      31
`define CUM_VAL_MSB       30
`define CUM_COUNT_RST     32'h80000000
`define CUM_SEL_MASK      32'h0f00ffff
`define CUM_NUM_STATES    4
`define CUM_MON_BITS      2
`define CUM_RIS_BITS      1
`define CUM_IDX_BITS      3
`define CUM_NUM_SLOTS     8
`define CUM_ST_SEC        2'h0
`define CUM_ST_NSEC       2'h1
`define CUM_ST_ROOT       2'h2
`define CUM_ST_REALM      2'h3
`endif

/* File: cum_props.sv */
// Assertions on the cache usage register bank ports
`timescale 1ns/1ps
module cum_props (
  input wire        clk,
  input wire        srst,
  input wire        req_valid,
  input wire        req_write,
  input wire [11:0] req_addr,
  input wire [1:0]  req_state,
  input wire        rsp_valid,
  input wire [31:0] rsp_rdata,
  input wire        realm_extension_feature,
  input wire        capture_present
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_rd;
    req_valid && !req_write;
  endsequence
  a_answer_next: assert property (req_valid |=> rsp_valid) else $error("no answer");
  a_no_extra: assert property (!req_valid |=> !rsp_valid) else $error("stray answer");
  a_write_zero: assert property (req_valid && req_write |=> !rsp_rdata) else $error("wr");
  a_realm_gate: assert property (s_rd ##0 req_state[1] && !realm_extension_feature
    |=> !rsp_rdata) else $error("realm gate");
  a_snap_gone: assert property (s_rd ##0 req_addr == 12'h848 && !capture_present
    |=> !rsp_rdata) else $error("snap absent");
  a_hole_zero: assert property (s_rd ##0 req_addr == 12'h844 |=> !rsp_rdata)
    else $error("hole");
  a_sel_mask: assert property (s_rd ##0 req_addr == 12'h800
    |=> !(rsp_rdata & 32'hf0ff0000)) else $error("sel mask");
  a_quiet_start: assert property ($fell(srst) |-> !rsp_valid)
    else $error("rsp after reset");
endmodule // cum_props
bind cum_regs cum_props i_cum_props (.*);

/* File: cum_regs.v */
// Cache usage monitor registers, one bank per security state
`timescale 1ns/1ps
`include "cum_defs.vh"
module cum_regs (
  input  wire        clk,
  input  wire        srst,
  input  wire        partitioning_present,
  input  wire        monitoring_present,
  input  wire        usage_monitor_present,
  input  wire        capture_present,
  input  wire        resource_select_present,
  input  wire        usage_readonly_flag,
  input  wire        realm_extension_feature,
  input  wire [1:0]  req_state,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [11:0] req_addr,
  input  wire [31:0] req_wdata,
  output reg  [31:0] rsp_rdata,
  output reg         rsp_valid,
  input  wire [31:0] mon_count,
  input  wire        mon_not_ready,
  input  wire        mon_update,
  input  wire [1:0]  mon_update_state,
  input  wire [2:0]  mon_update_idx,
  input  wire        capture_event
);

  localparam NS = `CUM_NUM_STATES;
  localparam NI = `CUM_NUM_SLOTS;
  localparam NT = NS * NI;

  // Flat slot index: state, resource, monitor
  function [4:0] slot;
    input [1:0]  st;
    input [31:0] sel;
    input        ris_on;
    begin
      slot = {st, (ris_on ? sel[`CUM_SEL_RIS_LSB] : 1'b0),            // [R04] [R05]
              sel[`CUM_SEL_MON_LSB+1:`CUM_SEL_MON_LSB]};
    end
  endfunction

  reg  [31:0] sel_reg   [0:NS-1];
  reg  [31:0] count_reg [0:NT-1];
  reg  [31:0] snap_reg  [0:NT-1];
  reg  [31:0] rsp_rdata_next;

  wire count_on = partitioning_present & monitoring_present & usage_monitor_present; // [R06]
  wire snap_on  = count_on & capture_present;                                       // [R14]
  // Root and realm pages exist only with the realm extension
  wire page_ok  = ~req_state[1] | realm_extension_feature;                          // [R03]
  wire acc      = req_valid & page_ok;
  wire [31:0] cur_sel = sel_reg[req_state];                                         // [R02]
  wire [4:0]  acc_slot = slot(req_state, cur_sel, resource_select_present);         // [R13]
  wire hit_sel   = acc & (req_addr == `CUM_OFF_SEL);
  wire hit_count = acc & (req_addr == `CUM_OFF_COUNT) & count_on;                   // [R11]
  wire hit_snap  = acc & (req_addr == `CUM_OFF_SNAP) & snap_on;
  wire [31:0] sel_mask = resource_select_present ? `CUM_SEL_MASK : 32'h0000ffff;    // [R17] [R18]

  genvar s, i;
  generate
    for (s = 0; s < NS; s = s + 1) begin : g_sel
      always @(posedge clk) begin
        if (srst) begin
          sel_reg[s] <= 32'h00000000;
        end else if (hit_sel && req_write && req_state == s) begin                  // [R01]
          sel_reg[s] <= req_wdata & sel_mask;
        end
      end
    end
    for (i = 0; i < NT; i = i + 1) begin : g_slot
      always @(posedge clk) begin
        if (srst) begin
          count_reg[i] <= `CUM_COUNT_RST;
        end else if (hit_count && req_write && !usage_readonly_flag && acc_slot == i) begin
          count_reg[i] <= req_wdata;                                     // [R07] [R10]
        end else if (mon_update && {mon_update_state, mon_update_idx} == i) begin
          count_reg[i] <= {mon_not_ready, mon_count[`CUM_VAL_MSB:0]};                // [R08] [R09]
        end
      end
      // Software write wins over a coincident capture; snapshot otherwise holds
      always @(posedge clk) begin
        if (srst) begin
          snap_reg[i] <= 32'h00000000;
        end else if (hit_snap && req_write && acc_slot == i) begin                   // [R12]
          snap_reg[i] <= req_wdata;
        end else if (capture_event && snap_on) begin
          snap_reg[i] <= count_reg[i];                           // [R15] [R16] [R19]
        end
      end
    end
  endgenerate

  always @* begin
    rsp_rdata_next = 32'h00000000;
    if (hit_sel) begin
      rsp_rdata_next = cur_sel;
    end else if (hit_count) begin
      rsp_rdata_next = count_reg[acc_slot];
    end else if (hit_snap) begin
      rsp_rdata_next = snap_reg[acc_slot];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rsp_rdata <= 32'h00000000;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      rsp_rdata <= (req_valid && !req_write) ? rsp_rdata_next : 32'h00000000;
    end
  end

endmodule // cum_regs

/* File: test_cum_regs.sv */
// Testbench for the cache usage register bank
`timescale 1ns/1ps
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module test_cum_regs;
  logic        clk = 0, srst = 1, req_valid = 0, req_write = 0, mon_update = 0;
  logic        partitioning_present = 1, monitoring_present = 1, usage_monitor_present = 1;
  logic        capture_present = 1, resource_select_present = 1, usage_readonly_flag = 0;
  logic        realm_extension_feature = 1, mon_not_ready = 0, capture_event = 0, rsp_valid;
  logic [1:0]  req_state = 0, mon_update_state = 0;
  logic [2:0]  mon_update_idx = 0;
  logic [11:0] req_addr = 0;
  logic [31:0] req_wdata = 0, mon_count = 0, rsp_rdata, v, sv[4], cv[4], exp_q[$];
  int          seed = 32'hbfc201e0, n_fail = 0, n_compared = 0;
  cum_regs i_cum_regs (.*);
  initial forever #50 clk = ~clk;
  initial #900000 begin n_fail++; stop_test; end
  // Reads and writes both answer; writes answer zero
  always @(posedge clk) if (rsp_valid === 1'b1) begin
    // Stray answer with nothing noted compares against unknown and fails
    v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxxxxxx;
    `CMP(rsp_rdata, v)
  end
  task automatic acc(input [1:0] s, input w, input [11:0] a, input [31:0] d, e);
    @(posedge clk) #10;
    {req_state, req_write, req_addr, req_wdata, req_valid} = {s, w, a, d, 1'b1};
    exp_q.push_back(w ? 32'h0 : e);
  endtask
  task automatic upd(input [1:0] s, input [2:0] i, input [31:0] c);
    @(posedge clk) #10;
    {req_valid, mon_update, mon_update_state, mon_update_idx, mon_not_ready} =
      {2'b01, s, i, c[31]};
    mon_count = c;
    @(posedge clk) #10 mon_update = 0;
  endtask
  task stop_test;
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #10 srst = 0;
    for (int s = 0; s < 4; s++) begin
      acc(s, 0, 12'h840, 0, 32'h80000000);
      acc(s, 0, 12'h848, 0, 0);
      sv[s] = $random(seed);
      cv[s] = $random(seed);
      acc(s, 1, 12'h800, sv[s], 0);
      acc(s, 0, 12'h800, 0, sv[s] & 32'h0f00ffff);
      upd(s, {sv[s][24], sv[s][1:0]}, cv[s]);
    end
    @(posedge clk) #10 capture_event = 1;
    @(posedge clk) #10 capture_event = 0;
    for (int s = 0; s < 4; s++) begin
      acc(s, 0, 12'h840, 0, cv[s]);
      upd(s, {sv[s][24], sv[s][1:0]}, 32'h7);
      acc(s, 0, 12'h848, 0, cv[s]);
    end
    upd(2, 3'b001, 32'h00000abc);
    upd(2, 3'b101, 32'h00000def);
    resource_select_present = 0;
    acc(2, 1, 12'h800, 32'h0f000001, 0);
    acc(2, 0, 12'h800, 0, 32'h00000001);
    acc(2, 0, 12'h840, 0, 32'h00000abc);
    acc(1, 1, 12'h840, 32'h1234, 0);
    acc(1, 0, 12'h840, 0, 32'h1234);
    usage_readonly_flag = 1;
    acc(1, 1, 12'h840, 32'h55, 0);
    acc(1, 0, 12'h840, 0, 32'h1234);
    realm_extension_feature = 0;
    acc(3, 0, 12'h840, 0, 0);
    capture_present = 0;
    acc(0, 0, 12'h848, 0, 0);
    monitoring_present = 0;
    acc(0, 0, 12'h840, 0, 0);
    acc(0, 0, 12'h844, 0, 0);
    @(posedge clk) #10 req_valid = 0;
    repeat (3) @(posedge clk);
    `CMP(exp_q.size(), 0)
    stop_test;
  end
endmodule // test_cum_regs
